/* design/msd_pkg.sv */
// Package for the multisample mode decoder: encodings, carriers, constants
package msd_pkg;

   // Raster multisample modes
   typedef enum logic [1:0] {
      MSD_RAST_OFF_PIXEL,
      MSD_RAST_OFF_PATTERN,
      MSD_RAST_ON_PIXEL,
      MSD_RAST_ON_PATTERN
   } msd_rast_mode_t;

   // Shader dispatch modes
   typedef enum logic {
      MSD_DISP_ONCE_PER_SAMPLE,
      MSD_DISP_ONCE_PER_PIXEL
   } msd_disp_mode_t;

   // Line algorithms
   typedef enum logic [1:0] {
      MSD_LINE_DIAMOND,
      MSD_LINE_WIDE,
      MSD_LINE_AA,
      MSD_LINE_MSAA
   } msd_line_alg_t;

   // Sample count encoding: log2 of samples (0 = single_sample_count)
   localparam int MSD_CNT_W = 2;
   localparam logic [MSD_CNT_W-1:0] MSD_SINGLE_SAMPLE_COUNT = 2'h0;
   localparam int MSD_NSAMP = 8;
   localparam int MSD_OFS_W = 8;
   localparam int MSD_STAT_W = 32;
   localparam logic [MSD_STAT_W-1:0] MSD_STAT_RST = 32'h0000_0000;
   localparam logic [3:0] MSD_RATE_ONE = 4'h1;
   localparam logic [15:0] MSD_LINE_WIDTH_ZERO = 16'h0000;

   // Mode state from the setup, windower and multisample state packets
   typedef struct packed {
      logic [MSD_CNT_W-1:0] sample_count;
      logic [MSD_CNT_W-1:0] raster_sample_count;
      msd_rast_mode_t       rast_mode;
      msd_disp_mode_t       disp_mode;
      logic                 target_independent_raster;
      logic                 line_aa_en;
      logic [15:0]          line_width;
      logic                 pixel_loc_center;
      logic                 stats_en;
   } msd_cfg_t;

   // Decoded operating mode
   typedef struct packed {
      msd_line_alg_t line_alg;
      logic [3:0]    rast_rate;
      logic          nonline_at_offsets;
      logic          lines_at_offsets;
      logic          use_raster_offsets;
      logic [3:0]    ps_rate;
      logic          ps_at_offsets_ok;
      logic [3:0]    om_rate;
      logic          depth_at_offsets;
      logic          invalid;
   } msd_mode_t;

   // One 2x2 group arriving from rasterization
   typedef struct packed {
      logic        valid;
      logic [3:0]  mask;
      logic [63:0] src_depth;
      logic [63:0] dst_depth;
   } msd_group_t;

   // Group handed to pixel shader dispatch
   typedef struct packed {
      logic        valid;
      logic [3:0]  mask;
      logic [3:0]  rate;
      logic [63:0] src_depth;
      logic [63:0] dst_depth;
   } msd_dispatch_t;

endpackage

/* design/msd_depth_test.sv */
// Early depth test of four pixels of a 2x2 group, source against destination
`timescale 1ns/100ps
`default_nettype none
module msd_depth_test
(
   input  wire logic [63:0] src_depth_in,
   input  wire logic [63:0] dst_depth_in,
   input  wire logic        stencil_pass_in,
   output logic [3:0]       pass_out
);
   // Less-than test on each 16-bit depth lane
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign pass_out[g] = stencil_pass_in &&
                              (src_depth_in[g*16 +: 16] < dst_depth_in[g*16 +: 16]);
      end
   endgenerate
endmodule
`default_nettype wire

/* design/msd_offset_sel.sv */
// Sample location select: pixel location or programmed per-sample offsets
`timescale 1ns/100ps
`default_nettype none
module msd_offset_sel
(
   input  wire logic                               at_offsets_in,
   input  wire logic                               use_raster_in,
   input  wire logic                               center_in,
   input  wire logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] msaa_ofs_in,
   input  wire logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] rast_ofs_in,
   output logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0]      loc_out
);
   // Pixel location: upper-left is 0, centre is half a pixel in x and y
   localparam logic [7:0] PIX_UL = 8'h00;
   localparam logic [7:0] PIX_CTR = 8'h88;
   wire [7:0] pix_loc = center_in ? PIX_CTR : PIX_UL;
   wire [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] ofs =
      use_raster_in ? rast_ofs_in : msaa_ofs_in;
   assign loc_out = at_offsets_in ? ofs : {msd_pkg::MSD_NSAMP{pix_loc}};
endmodule
`default_nettype wire

/* design/msd_mode_decoder.sv */
// Multisample mode decoder of the windower stage with early depth and statistics
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - line-multisampling-on modes draw MSAA rectangle lines, no alpha coverage.
// - lines off, AA off: zero width diamond, else wide non-AA lines.
// - lines off, AA on: non-zero width AA lines, zero width diamond.
// - one sample, off-pixel: one raster, legacy/AA lines, one shader, one merge.
// - one sample, on-pixel: one raster, MSAA lines, one shader, one merge.
// - one sample without independent raster: per-sample dispatch acts as per-pixel.
// - n samples, off-pixel, per-pixel: one raster, one shader, merge per sample.
// - n samples, pixel mode, per-sample: n shader runs at pixel, n merges.
// - n samples, on-pixel: one raster, MSAA lines, shader rate per dispatch.
// - n samples, off-pattern: non-lines n times at offsets, lines at pixel.
// - pattern, per-sample: n shader runs; per-pixel: one at pixel location.
// - n samples, on-pattern: all n times at offsets, MSAA lines, n merges.
// - independent raster enable selects raster count and raster offsets.
// - independent raster ignores dispatch mode; per-sample is then invalid.
// - independent, off-pattern: non-lines n times, one shader and merge.
// - independent, on-pattern: n rasters, MSAA lines, one shader and merge.
// - pixel location upper-left or centre; samples at programmed offsets.
// - statistics count each unmasked pixel or sample dispatched to shading.
// - early-discarded pixels or samples are still counted.
// - early test uses interpolated and cached depth; both go in payload when the shader uses depth.
// - partial discard clears mask bits; full discard skips dispatch.
module msd_mode_decoder
(
   input  wire logic                sys_clk_in,
   input  wire logic                rst_in,
   input  wire msd_pkg::msd_cfg_t   cfg_in,
   input  wire logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] msaa_ofs_in,
   input  wire logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] rast_ofs_in,
   input  wire msd_pkg::msd_group_t group_in,
   input  wire logic                stencil_pass_in,
   input  wire logic                ps_uses_depth_in,
   input  wire logic                ps_kill_or_depth_in,
   input  wire logic                stat_clear_in,
   output msd_pkg::msd_mode_t       mode_out,
   output logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] sample_loc_out,
   output msd_pkg::msd_dispatch_t   dispatch_out,
   output logic [msd_pkg::MSD_STAT_W-1:0] shader_invocation_counter_out,
   output logic                     prog_error_out
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Samples per pixel from the log2 count
   function automatic logic [3:0] samples(input logic [msd_pkg::MSD_CNT_W-1:0] c);
      samples = 4'(1 << c);
   endfunction

   // Count of set bits in a 2x2 mask
   function automatic logic [2:0] popcnt4(input logic [3:0] m);
      popcnt4 = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
   endfunction

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire       ind_rast = cfg_in.target_independent_raster;
   wire [1:0] eff_cnt  = ind_rast ? cfg_in.raster_sample_count : cfg_in.sample_count;
   wire [3:0] n        = samples(eff_cnt);
   wire       multi    = (eff_cnt != msd_pkg::MSD_SINGLE_SAMPLE_COUNT);
   wire       lines_on = (cfg_in.rast_mode == msd_pkg::MSD_RAST_ON_PIXEL) ||
                         (cfg_in.rast_mode == msd_pkg::MSD_RAST_ON_PATTERN);
   wire       pattern  = (cfg_in.rast_mode == msd_pkg::MSD_RAST_OFF_PATTERN) ||
                         (cfg_in.rast_mode == msd_pkg::MSD_RAST_ON_PATTERN);
   wire       width_zero = (cfg_in.line_width == msd_pkg::MSD_LINE_WIDTH_ZERO);
   // single sample folds per-sample into per-pixel (per_sample low, rate one)
   // dispatch mode disregarded under independent raster
   wire       per_sample = !ind_rast && multi &&
                           (cfg_in.disp_mode == msd_pkg::MSD_DISP_ONCE_PER_SAMPLE);

   // multisampled lines whenever lines mode is on
   // diamond at zero width, AA when line_aa_en is set, wide otherwise
   msd_pkg::msd_line_alg_t line_alg;
   assign line_alg = lines_on ? msd_pkg::MSD_LINE_MSAA :
                     width_zero ? msd_pkg::MSD_LINE_DIAMOND :
                     cfg_in.line_aa_en ? msd_pkg::MSD_LINE_AA : msd_pkg::MSD_LINE_WIDE;

   // single-sample pixel modes rasterize once at pixel
   // single-sample lines-on uses MSAA lines once
   // pattern off: non-lines n times, lines at pixel
   // pattern on: all primitives at offsets
   // independent off-pattern rasterizes non-lines n times
   wire [3:0] rast_rate   = (pattern && multi) ? n : msd_pkg::MSD_RATE_ONE;
   wire       nonline_ofs = pattern && multi;
   wire       line_ofs    = pattern && multi && lines_on;

   // pattern per-sample shading n times at pixel or offsets
   wire [3:0] ps_rate     = per_sample ? n : msd_pkg::MSD_RATE_ONE;
   wire       ps_ofs_ok   = per_sample && pattern;

   // merge per sample without independent raster
   // independent raster merges once at pixel
   wire [3:0] om_rate     = ind_rast ? msd_pkg::MSD_RATE_ONE : n;
   wire       depth_ofs   = pattern && multi && !ind_rast;

   // per-sample value invalid with independent raster
   wire       invalid = (pattern && !multi) ||
                        (ind_rast && multi && !pattern) ||
                        (ind_rast && cfg_in.disp_mode == msd_pkg::MSD_DISP_ONCE_PER_SAMPLE);

   msd_pkg::msd_mode_t nxt_mode;
   assign nxt_mode = '{line_alg: line_alg, rast_rate: rast_rate,
                       nonline_at_offsets: nonline_ofs, lines_at_offsets: line_ofs,
                       use_raster_offsets: ind_rast, ps_rate: ps_rate,
                       ps_at_offsets_ok: ps_ofs_ok, om_rate: om_rate,
                       depth_at_offsets: depth_ofs, invalid: invalid};

   // ----------------------------------------------------------------
   // Sample locations
   // ----------------------------------------------------------------
   logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] nxt_loc;
   // independent raster chooses its own offsets
   msd_offset_sel u_ofs
   (
      .at_offsets_in (nonline_ofs),
      .use_raster_in (ind_rast),
      .center_in     (cfg_in.pixel_loc_center),
      .msaa_ofs_in   (msaa_ofs_in),
      .rast_ofs_in   (rast_ofs_in),
      .loc_out       (nxt_loc)
   );

   // ----------------------------------------------------------------
   // Early depth and stencil
   // ----------------------------------------------------------------
   logic [3:0] pass;
   // test interpolated source against cached destination
   msd_depth_test u_dt
   (
      .src_depth_in    (group_in.src_depth),
      .dst_depth_in    (group_in.dst_depth),
      .stencil_pass_in (stencil_pass_in),
      .pass_out        (pass)
   );
   // Shader kill or computed depth forbids early discard
   wire [3:0] kept = ps_kill_or_depth_in ? group_in.mask : (group_in.mask & pass);

   // drop mask bits, skip fully discarded group
   msd_pkg::msd_dispatch_t nxt_disp;
   assign nxt_disp.valid     = group_in.valid && (kept != 4'h0);
   assign nxt_disp.mask      = kept;
   assign nxt_disp.rate      = ps_rate;
   // both depths in payload when required
   assign nxt_disp.src_depth = ps_uses_depth_in ? group_in.src_depth : 64'h0;
   assign nxt_disp.dst_depth = ps_uses_depth_in ? group_in.dst_depth : 64'h0;

   // ----------------------------------------------------------------
   // Statistics
   // ----------------------------------------------------------------
   // count unmasked pixels times shader rate
   // count before early discard, using incoming mask
   wire [6:0] inc = 7'({4'h0, popcnt4(group_in.mask)} * {3'h0, ps_rate});
   logic [msd_pkg::MSD_STAT_W-1:0] nxt_stat;
   assign nxt_stat = stat_clear_in ? msd_pkg::MSD_STAT_RST :
                     (cfg_in.stats_en && group_in.valid) ?
                     shader_invocation_counter_out + {25'h0, inc} :
                     shader_invocation_counter_out;

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   msd_pkg::msd_mode_t             mode_ff;
   logic [msd_pkg::MSD_NSAMP*msd_pkg::MSD_OFS_W-1:0] loc_ff;
   msd_pkg::msd_dispatch_t         disp_ff;
   logic [msd_pkg::MSD_STAT_W-1:0] stat_ff;
   logic                           err_ff;

   // Register decode results and dispatch
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         mode_ff <= '0;
         loc_ff  <= '0;
         disp_ff <= '0;
         stat_ff <= msd_pkg::MSD_STAT_RST;
         err_ff  <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         loc_ff  <= nxt_loc;
         disp_ff <= nxt_disp;
         stat_ff <= nxt_stat;
         err_ff  <= invalid;
      end
   end

   assign mode_out                      = mode_ff;
   assign sample_loc_out                = loc_ff;
   assign dispatch_out                  = disp_ff;
   assign shader_invocation_counter_out = stat_ff;
   assign prog_error_out                = err_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_lines_on;
      lines_on;
   endsequence

   msd_lines_msaa_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      s_lines_on |=> mode_out.line_alg == msd_pkg::MSD_LINE_MSAA)
      else $error("lines-on mode did not give multisampled lines");
   msd_diamond_line_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!lines_on && width_zero) |=> mode_out.line_alg == msd_pkg::MSD_LINE_DIAMOND)
      else $error("zero width did not give diamond line");
   msd_aa_line_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!lines_on && !width_zero && cfg_in.line_aa_en)
      |=> mode_out.line_alg == msd_pkg::MSD_LINE_AA)
      else $error("anti-aliased line not selected");
   msd_single_rate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!multi && !rst_in) |=> (mode_out.rast_rate == 4'h1 && mode_out.ps_rate == 4'h1
                  && mode_out.om_rate == 4'h1))
      else $error("single sample rates not one");
   msd_dispatch_once_per_sample_ps_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      per_sample |=> mode_out.ps_rate == $past(n))
      else $error("per-sample shader rate wrong");
   msd_ind_rates_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ind_rast && !rst_in) |=> (mode_out.om_rate == 4'h1 && mode_out.ps_rate == 4'h1))
      else $error("independent raster rates not one");
   msd_group_skip_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (group_in.valid && kept == 4'h0) |=> !dispatch_out.valid)
      else $error("fully discarded group dispatched");
   msd_stat_count_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (cfg_in.stats_en && group_in.valid && !stat_clear_in)
      |=> shader_invocation_counter_out ==
          $past(shader_invocation_counter_out) + {25'h0, $past(inc)})
      else $error("invocation counter missed pixels");
   msd_invalid_flag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (pattern && !multi) |=> prog_error_out)
      else $error("invalid pattern mode not flagged");

endmodule
`default_nettype wire

/* verif/msd_ps_sink.sv */
// Shader dispatch side model that takes in every group handed over
`timescale 1ns/100ps
`default_nettype none
module msd_ps_sink
(
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_in,
   input  wire msd_pkg::msd_dispatch_t dispatch_in,
   output logic [15:0]                 rx_cnt_out,
   output logic                        empty_seen_out
);
   // -----------------------------------------------
   // Group intake, always ready
   // -----------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         rx_cnt_out     <= 16'h0000;
         empty_seen_out <= 1'b0;
      end
      else if (dispatch_in.valid)
      begin
         rx_cnt_out <= rx_cnt_out + 16'h0001;
         if (dispatch_in.mask == 4'h0)
            empty_seen_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* verif/msd_mode_decoder_tb.sv */
// Self-checking bench for the multisample mode decoder
`timescale 1ns/100ps
`default_nettype none
module msd_mode_decoder_tb;
   localparam logic [63:0] DST = 64'h8000_8000_8000_8000;
   logic                   sys_clk_in = 1'b0;
   logic                   rst_in = 1'b1;
   msd_pkg::msd_cfg_t      cfg = '0;
   logic [63:0]            msaa_ofs = 64'h1357_9BDF_2468_ACE0;
   logic [63:0]            rast_ofs = 64'hF0E1_D2C3_B4A5_9687;
   msd_pkg::msd_group_t    grp = '0;
   logic                   stencil = 1'b1;
   logic                   uses_depth = 1'b0;
   logic                   kill_depth = 1'b0;
   logic                   stat_clear = 1'b0;
   msd_pkg::msd_mode_t     mode_out;
   logic [63:0]            loc_out;
   msd_pkg::msd_dispatch_t disp_out;
   logic [31:0]            cnt_out;
   logic                   err_out;
   logic [15:0]            rx_cnt;
   logic                   empty_seen;
   int                     n_mismatch = 0;
   int                     tests_run = 0;
   int                     cyc = 0;
   logic [31:0]            exp_cnt = 32'h0000_0000;
   logic [15:0]            exp_rx = 16'h0000;

   always #50 sys_clk_in = ~sys_clk_in;

   msd_mode_decoder dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cfg_in(cfg),
      .msaa_ofs_in(msaa_ofs), .rast_ofs_in(rast_ofs), .group_in(grp),
      .stencil_pass_in(stencil), .ps_uses_depth_in(uses_depth),
      .ps_kill_or_depth_in(kill_depth), .stat_clear_in(stat_clear), .mode_out(mode_out),
      .sample_loc_out(loc_out), .dispatch_out(disp_out),
      .shader_invocation_counter_out(cnt_out), .prog_error_out(err_out));

   msd_ps_sink sink (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .dispatch_in(disp_out),
      .rx_cnt_out(rx_cnt), .empty_seen_out(empty_seen));

   // -----------------------------------------------
   // Reference model and access tasks
   // -----------------------------------------------
   function automatic msd_pkg::msd_mode_t exp_mode(input msd_pkg::msd_cfg_t c);
      msd_pkg::msd_mode_t m;
      logic [1:0]         rm;
      logic [1:0]         cnt;
      logic [3:0]         n;
      logic               rt;
      logic               multi;
      logic               ps_n;
      m = '0;
      rm = c.rast_mode;
      rt = c.target_independent_raster;
      cnt = rt ? c.raster_sample_count : c.sample_count;
      n = 4'h1 << cnt;
      multi = (cnt != msd_pkg::MSD_SINGLE_SAMPLE_COUNT);
      ps_n = multi && !rt && (c.disp_mode == msd_pkg::MSD_DISP_ONCE_PER_SAMPLE);
      m.line_alg = rm[1] ? msd_pkg::MSD_LINE_MSAA
         : (c.line_width == msd_pkg::MSD_LINE_WIDTH_ZERO) ? msd_pkg::MSD_LINE_DIAMOND
         : c.line_aa_en ? msd_pkg::MSD_LINE_AA : msd_pkg::MSD_LINE_WIDE;
      m.rast_rate = (rm[0] && multi) ? n : msd_pkg::MSD_RATE_ONE;
      m.nonline_at_offsets = rm[0] && multi;
      m.lines_at_offsets = rm[1] && rm[0] && multi;
      m.use_raster_offsets = rt;
      m.ps_rate = ps_n ? n : msd_pkg::MSD_RATE_ONE;
      m.ps_at_offsets_ok = ps_n && rm[0];
      m.om_rate = (multi && !rt) ? n : msd_pkg::MSD_RATE_ONE;
      m.depth_at_offsets = rm[0] && multi && !rt;
      m.invalid = (rm[0] && !multi) || (rt && multi && !rm[0])
         || (rt && c.disp_mode == msd_pkg::MSD_DISP_ONCE_PER_SAMPLE);
      return m;
   endfunction

   function automatic logic [63:0] mk_src(input logic [3:0] fail);
      logic [63:0] s;
      s = '0;
      for (int g = 0; g < 4; g++)
         s[g*16 +: 16] = fail[g] ? 16'hF000 : 16'h1000;
      return s;
   endfunction

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Applies a mode state and checks decode, locations and error flag
   task automatic apply_cfg(input msd_pkg::msd_cfg_t c);
      msd_pkg::msd_mode_t m;
      logic [63:0]        loc;
      m = exp_mode(c);
      loc = m.nonline_at_offsets ? (c.target_independent_raster ? rast_ofs : msaa_ofs)
         : {8{c.pixel_loc_center ? 8'h88 : 8'h00}};
      @(posedge sys_clk_in);
      cfg <= c;
      @(posedge sys_clk_in);
      #1;
      chk("prog_error", 64'(m.invalid), 64'(err_out));
      if (!m.invalid)
      begin
         chk("mode", 64'(m), 64'(mode_out));
         chk("sample_loc", loc, loc_out);
      end
   endtask

   // Sends one 2x2 group and checks the dispatch and the counter
   task automatic send_grp(input logic [3:0] msk, input logic [3:0] fail, input logic stp,
                           input logic u, input logic k, input logic [3:0] exp_m);
      msd_pkg::msd_mode_t m;
      m = exp_mode(cfg);
      @(posedge sys_clk_in);
      grp <= '{1'b1, msk, mk_src(fail), DST};
      stencil <= stp;
      uses_depth <= u;
      kill_depth <= k;
      @(posedge sys_clk_in);
      grp.valid <= 1'b0;
      #1;
      if (cfg.stats_en)
         exp_cnt = exp_cnt + 32'($countones(msk)) * 32'(m.ps_rate);
      if (exp_m != 4'h0)
         exp_rx = exp_rx + 16'h0001;
      chk("disp_valid", 64'(exp_m != 4'h0), 64'(disp_out.valid));
      chk("counter", 64'(exp_cnt), 64'(cnt_out));
      if (exp_m != 4'h0)
      begin
         chk("disp_mask", 64'(exp_m), 64'(disp_out.mask));
         chk("disp_rate", 64'(m.ps_rate), 64'(disp_out.rate));
         chk("src_depth", u ? mk_src(fail) : 64'h0, disp_out.src_depth);
         chk("dst_depth", u ? DST : 64'h0, disp_out.dst_depth);
      end
   endtask

   // Hang guard
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial
   begin
      msd_pkg::msd_cfg_t c;
      repeat (11) @(posedge sys_clk_in);
      #1;
      chk("rst_mode", 64'h0, 64'(mode_out));
      chk("rst_counter", 64'h0, 64'(cnt_out));
      @(posedge sys_clk_in);
      rst_in <= 1'b0;
      $display("test reset done");
      for (int i = 0; i < 64; i++)
      begin
         c = '0;
         c.sample_count = i[1:0];
         c.raster_sample_count = ~i[1:0];
         c.rast_mode = msd_pkg::msd_rast_mode_t'(i[3:2]);
         c.disp_mode = msd_pkg::msd_disp_mode_t'(i[4]);
         c.target_independent_raster = i[5];
         c.line_aa_en = i[2] ^ i[5];
         c.line_width = (i[1] ^ i[4]) ? 16'h0100 : 16'h0000;
         c.pixel_loc_center = i[3] ^ i[0];
         apply_cfg(c);
      end
      $display("test mode sweep done");
      c = '0;
      c.sample_count = 2'h2;
      c.stats_en = 1'b1;
      apply_cfg(c);
      send_grp(4'hF, 4'h0, 1'b1, 1'b0, 1'b0, 4'hF);
      send_grp(4'hF, 4'hA, 1'b1, 1'b1, 1'b0, 4'h5);
      send_grp(4'h6, 4'hF, 1'b1, 1'b1, 1'b0, 4'h0);
      send_grp(4'hF, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
      send_grp(4'hF, 4'hF, 1'b1, 1'b0, 1'b1, 4'hF);
      send_grp(4'h3, 4'h0, 1'b1, 1'b1, 1'b0, 4'h3);
      @(posedge sys_clk_in);
      stat_clear <= 1'b1;
      @(posedge sys_clk_in);
      stat_clear <= 1'b0;
      #1;
      exp_cnt = 32'h0000_0000;
      chk("counter_clear", 64'h0, 64'(cnt_out));
      c.stats_en = 1'b0;
      apply_cfg(c);
      send_grp(4'hF, 4'h0, 1'b1, 1'b0, 1'b0, 4'hF);
      c.stats_en = 1'b1;
      c.disp_mode = msd_pkg::MSD_DISP_ONCE_PER_PIXEL;
      apply_cfg(c);
      send_grp(4'hF, 4'h1, 1'b1, 1'b0, 1'b0, 4'hE);
      $display("test dispatch done");
      for (int k = 0; k < 3; k++)
      begin
         @(posedge sys_clk_in);
         grp <= '{1'b1, 4'hF >> k, mk_src(4'h0), DST};
      end
      @(posedge sys_clk_in);
      grp.valid <= 1'b0;
      @(posedge sys_clk_in);
      #1;
      exp_cnt = exp_cnt + 32'd9;
      exp_rx = exp_rx + 16'h0003;
      chk("burst_counter", 64'(exp_cnt), 64'(cnt_out));
      chk("sink_groups", 64'(exp_rx), 64'(rx_cnt));
      chk("sink_empty", 64'h0, 64'(empty_seen));
      $display("test burst done");
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      @(posedge sys_clk_in);
      rst_in <= 1'b0;
      #1;
      chk("rerst_counter", 64'h0, 64'(cnt_out));
      chk("rerst_mode", 64'h0, 64'(mode_out));
      $display("test second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
